// [common/sair_if.sv]
// Serial audio link between the source and the receiver
`timescale 1ns/1ns
interface sair_if;
  logic serial_bit_clock;
  logic frame_word_clock;
  logic serial_data_in;

  // Source drives every wire, receiver only listens
  modport src (
    output serial_bit_clock,
    output frame_word_clock,
    output serial_data_in
  );
  modport rx (
    input  serial_bit_clock,
    input  frame_word_clock,
    input  serial_data_in
  );
endinterface

// [common/sair_pkg.sv]
// Shared formats, constants and helpers for the serial audio input link
package sair_pkg;

  // Serial formats, one-hot
  typedef enum logic [3:0] {
    SAIR_RJ  = 4'h1,
    SAIR_OL1 = 4'h2,
    SAIR_OL2 = 4'h4,
    SAIR_TDM = 4'h8
  } sair_mode_t;

  // Word length codes
  typedef logic [2:0] sair_wl_t;
  localparam sair_wl_t SAIR_WL16 = 3'h0;
  localparam sair_wl_t SAIR_WL18 = 3'h1;
  localparam sair_wl_t SAIR_WL20 = 3'h2;
  localparam sair_wl_t SAIR_WL24 = 3'h3;
  localparam sair_wl_t SAIR_WL32 = 3'h4;

  // Clock periods and the bit clock divider derived from them
  localparam int SAIR_CORE_PERIOD_NS = 40;
  localparam int SAIR_LINK_PERIOD_NS = 160;
  localparam int SAIR_HALF_DIV       = SAIR_LINK_PERIOD_NS / (2 * SAIR_CORE_PERIOD_NS);

  // Slot widths, slot counts and frame lengths in bit clocks
  localparam logic [5:0] SAIR_OL1_SLOT_BITS  = 6'h14;
  localparam logic [5:0] SAIR_OL2_SLOT_BITS  = 6'h18;
  localparam logic [5:0] SAIR_TDM_SLOT_BITS  = 6'h20;
  localparam logic [3:0] SAIR_RJ_SLOTS       = 4'h2;
  localparam logic [3:0] SAIR_OL1_SLOTS      = 4'h6;
  localparam logic [3:0] SAIR_OL2_SLOTS      = 4'ha;
  localparam logic [3:0] SAIR_TDM_SLOTS      = 4'h8;
  localparam logic [8:0] SAIR_OL1_FRAME_BITS = 9'h080;
  localparam logic [8:0] SAIR_OL2_FRAME_BITS = 9'h100;
  localparam logic [8:0] SAIR_TDM_FRAME_BITS = 9'h100;
  localparam logic [8:0] SAIR_OL1_HIGH_BITS  = 9'h040;
  localparam logic [8:0] SAIR_OL2_HIGH_BITS  = 9'h080;
  localparam int         SAIR_RJ_HALF_BITS   = 32;

  // Values after reset
  localparam logic [31:0] SAIR_SAMPLE_RST = 32'h0;
  localparam logic [3:0]  SAIR_SLOT_RST   = 4'h0;

  // Bits in a word of the given length code
  function automatic logic [5:0] sair_wl_bits(input sair_wl_t wl);
    case (wl)
      SAIR_WL18: sair_wl_bits = 6'h12;
      SAIR_WL20: sair_wl_bits = 6'h14;
      SAIR_WL24: sair_wl_bits = 6'h18;
      SAIR_WL32: sair_wl_bits = 6'h20;
      default:   sair_wl_bits = 6'h10;
    endcase
  endfunction

  // Right-justified words are only 16 or 24 bits; others fall back to 16
  function automatic logic [5:0] sair_rj_bits(input sair_wl_t wl);
    sair_rj_bits = (wl == SAIR_WL24) ? 6'h18 : 6'h10;
  endfunction

  // Slot width of a framed format
  function automatic logic [5:0] sair_slot_bits(input sair_mode_t m);
    case (m)
      SAIR_OL1: sair_slot_bits = SAIR_OL1_SLOT_BITS;
      SAIR_OL2: sair_slot_bits = SAIR_OL2_SLOT_BITS;
      default:  sair_slot_bits = SAIR_TDM_SLOT_BITS;
    endcase
  endfunction

  // Number of slots in a frame
  function automatic logic [3:0] sair_nslots(input sair_mode_t m);
    case (m)
      SAIR_RJ:  sair_nslots = SAIR_RJ_SLOTS;
      SAIR_OL1: sair_nslots = SAIR_OL1_SLOTS;
      SAIR_OL2: sair_nslots = SAIR_OL2_SLOTS;
      default:  sair_nslots = SAIR_TDM_SLOTS;
    endcase
  endfunction

endpackage

// [design/sair_rx.sv]
// Serial audio receiver: link-clocked capture, samples handed to core clock
`timescale 1ns/1ns
module sair_rx
  import sair_pkg::*;
(
  // Core clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Static format selection
  input  wire sair_mode_t  cfg_mode,
  input  wire sair_wl_t    cfg_wl,
  // Serial link
  sair_if.rx               link,
  // Received samples
  output logic [31:0]      rx_sample,
  output logic [3:0]       rx_slot,
  output logic             rx_valid
);

  // Link domain reset and configuration copies
  logic        lrst_s1;
  logic        lrst;
  sair_mode_t  mode_s1;
  sair_mode_t  mode_l;
  sair_wl_t    wl_s1;
  sair_wl_t    wl_l;

  // Link domain capture state
  logic        lrck_q;
  logic        framed;
  logic [5:0]  pos;
  logic [3:0]  slot;
  logic [31:0] shreg;
  logic [31:0] hold_sample;
  logic [3:0]  hold_slot;
  logic        ev_tgl;

  // Link domain decode
  logic        lrck;
  logic        sdata;
  logic        start;
  logic        rj_edge;
  logic        oneline;
  logic [5:0]  slot_bits;
  logic [3:0]  nslots;
  logic [5:0]  cur_pos;
  logic [3:0]  cur_slot;
  logic        framed_eff;
  logic [31:0] next_shreg;
  logic [31:0] left_j;
  logic [31:0] wl_mask;
  logic        next_emit;
  logic [31:0] next_sample;
  logic [3:0]  next_slot;
  logic [5:0]  next_pos;
  logic [3:0]  next_slot_no;

  // Core domain crossing state
  logic        tg_s1;
  logic        tg_s2;
  logic        tg_s3;

  // Reset is asserted in the link domain at once and released through two flops;
  // the source stops the bit clock in reset, so a clocked copy would never see it
  always_ff @(posedge link.serial_bit_clock or posedge rst)
  begin
    if (rst)
    begin
      lrst_s1 <= 1'b1;
      lrst    <= 1'b1;
    end
    else
    begin
      lrst_s1 <= 1'b0;
      lrst    <= lrst_s1;
    end
  end

  // Format inputs change only while the bit clock is stopped, so a plain
  // two-flop copy with no reset is settled before the link domain leaves reset
  always_ff @(posedge link.serial_bit_clock)
  begin
    mode_s1 <= cfg_mode;
    mode_l  <= mode_s1;
    wl_s1   <= cfg_wl;
    wl_l    <= wl_s1;
  end

  // Word clock and data are launched by the source on the same clock
  assign lrck  = link.frame_word_clock;
  assign sdata = link.serial_data_in;

  // Frame and half-frame markers
  always_comb
  begin
    start   = lrck & ~lrck_q;
    rj_edge = lrck ^ lrck_q;
    oneline = (mode_l == SAIR_OL1) || (mode_l == SAIR_OL2);
  end

  // Slot geometry of the selected format
  always_comb
  begin
    slot_bits = sair_slot_bits(mode_l);
    nslots    = sair_nslots(mode_l);
    wl_mask   = ~(32'hffffffff >> sair_wl_bits(wl_l));
  end

  // One-line frames start on the edge that also carries the first MSB,
  // while in TDM that edge still finishes the previous frame
  always_comb
  begin
    if (oneline && start)
    begin
      cur_pos  = 6'h00;
      cur_slot = 4'h0;
    end
    else
    begin
      cur_pos  = pos;
      cur_slot = slot;
    end
    framed_eff = framed | (oneline & start);
  end

  // Shift in the current bit, restarting at each slot boundary in the framed formats
  always_comb
  begin
    if (mode_l == SAIR_RJ)
      next_shreg = {shreg[30:0], sdata};
    else if (cur_pos == 6'h00)
      next_shreg = {31'h0, sdata};
    else
      next_shreg = {shreg[30:0], sdata};
    left_j = next_shreg << (6'h20 - slot_bits);
  end

  // Decide whether this edge completes a word, and what that word is
  always_comb
  begin
    next_emit   = 1'b0;
    next_sample = SAIR_SAMPLE_RST;
    next_slot   = SAIR_SLOT_RST;
    if (mode_l == SAIR_RJ)
    begin
      // The LSB came on the previous edge, so the stored bits form the word
      next_emit   = framed & rj_edge;
      next_sample = shreg << (6'h20 - sair_rj_bits(wl_l));
      next_slot   = lrck_q ? 4'h0 : 4'h1;
    end
    else
    begin
      next_emit   = framed_eff && (cur_pos == slot_bits - 6'h01) && (cur_slot < nslots);
      next_sample = left_j & wl_mask;
      next_slot   = cur_slot;
    end
  end

  // Position of the next bit within its slot
  always_comb
  begin
    if (cur_pos == slot_bits - 6'h01)
    begin
      next_pos     = 6'h00;
      next_slot_no = (cur_slot == 4'hf) ? cur_slot : cur_slot + 4'h1;
    end
    else
    begin
      next_pos     = cur_pos + 6'h01;
      next_slot_no = cur_slot;
    end
    if ((mode_l == SAIR_TDM) && start)
    begin
      next_pos     = 6'h00;
      next_slot_no = 4'h0;
    end
  end

  // Word clock history is sampled on every rise, reset or not,
  // so no false frame start follows the release of reset
  always_ff @(posedge link.serial_bit_clock)
  begin
    lrck_q <= lrck;
  end

  // Serial capture on the bit clock rise
  always_ff @(posedge link.serial_bit_clock)
  begin
    if (lrst)
      shreg <= SAIR_SAMPLE_RST;
    else
      shreg <= next_shreg;
  end

  // Slot counters run from reset; no word is emitted until the first frame marker is seen
  always_ff @(posedge link.serial_bit_clock)
  begin
    if (lrst)
    begin
      framed <= 1'b0;
      pos    <= 6'h00;
      slot   <= 4'h0;
    end
    else
    begin
      if ((mode_l == SAIR_RJ) ? rj_edge : start)
        framed <= 1'b1;
      pos  <= next_pos;
      slot <= next_slot_no;
    end
  end

  // Completed words are held until the next one, and announced by a toggle;
  // cleared at once in reset so that no stale toggle reaches the core side
  always_ff @(posedge link.serial_bit_clock or posedge lrst)
  begin
    if (lrst)
    begin
      hold_sample <= SAIR_SAMPLE_RST;
      hold_slot   <= SAIR_SLOT_RST;
      ev_tgl      <= 1'b0;
    end
    else if (next_emit)
    begin
      hold_sample <= next_sample;
      hold_slot   <= next_slot;
      ev_tgl      <= ~ev_tgl;
    end
  end

  // Toggle synchroniser; only the second and third flops are compared
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tg_s1 <= 1'b0;
      tg_s2 <= 1'b0;
      tg_s3 <= 1'b0;
    end
    else
    begin
      tg_s1 <= ev_tgl;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
    end
  end

  // Held words are three core cycles old when the toggle arrives,
  // so they are stable to copy; the next word is at least 16 bit clocks away
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rx_sample <= SAIR_SAMPLE_RST;
      rx_slot   <= SAIR_SLOT_RST;
      rx_valid  <= 1'b0;
    end
    else
    begin
      rx_valid <= tg_s2 ^ tg_s3;
      if (tg_s2 ^ tg_s3)
      begin
        rx_sample <= hold_sample;
        rx_slot   <= hold_slot;
      end
    end
  end

endmodule

// [design/sair_src.sv]
// Serial audio source: makes the bit clock by division and sends frames
`timescale 1ns/1ns
module sair_src
  import sair_pkg::*;
#(
  parameter int HALF_DIV = SAIR_HALF_DIV,
  parameter int RJ_HALF  = SAIR_RJ_HALF_BITS
)
(
  // Core clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Static format selection
  input  wire sair_mode_t  cfg_mode,
  input  wire sair_wl_t    cfg_wl,
  // Serial link
  sair_if.src              link,
  // Sample supply
  input  wire logic [31:0] tx_data,
  output logic [3:0]       tx_slot,
  output logic             tx_load
);

  localparam logic [7:0] DIV_LAST = 8'(HALF_DIV - 1);
  localparam logic [7:0] RJ_W     = 8'(RJ_HALF);
  // 256 Fs formats run the bit clock twice as fast to keep the frame rate in range
  localparam logic [7:0] DIV_LAST_FAST = 8'((HALF_DIV > 1) ? HALF_DIV / 2 - 1 : 0);

  logic [7:0]  dcnt;
  logic [7:0]  div_last;
  logic        sclk;
  logic        lrck;
  logic        sdo;
  logic [8:0]  b;
  logic [7:0]  pos;
  logic [3:0]  slot;
  logic [31:0] word;

  logic        fall;
  logic        rj;
  logic [7:0]  w;
  logic [8:0]  fl;
  logic [3:0]  nslots;
  logic [7:0]  wlb;
  logic [7:0]  lead;
  logic        wrap;
  logic [8:0]  nb;
  logic [7:0]  npos;
  logic [3:0]  nslot;
  logic        load;
  logic [31:0] wsrc;
  logic [7:0]  bidx;
  logic        next_sdo;
  logic        next_lrck;

  // Frame geometry
  always_comb
  begin
    rj     = (cfg_mode == SAIR_RJ);
    div_last = (cfg_mode == SAIR_OL2 || cfg_mode == SAIR_TDM) ? DIV_LAST_FAST : DIV_LAST;
    w      = rj ? RJ_W : {2'h0, sair_slot_bits(cfg_mode)};
    nslots = sair_nslots(cfg_mode);
    wlb    = rj ? {2'h0, sair_rj_bits(cfg_wl)} : {2'h0, sair_wl_bits(cfg_wl)};
    lead   = rj ? w - wlb : 8'h00;
    case (cfg_mode)
      SAIR_OL1: fl = SAIR_OL1_FRAME_BITS;
      SAIR_OL2: fl = SAIR_OL2_FRAME_BITS;
      SAIR_TDM: fl = SAIR_TDM_FRAME_BITS;
      default:  fl = {w, 1'b0};
    endcase
  end

  // Next bit position; a counter at or past the end restarts the frame
  always_comb
  begin
    fall = (dcnt == div_last) && sclk;
    wrap = (b >= fl - 9'h001);
    nb   = wrap ? 9'h000 : b + 9'h001;
    if (wrap)
    begin
      npos  = 8'h00;
      nslot = 4'h0;
    end
    else if (pos == w - 8'h01)
    begin
      npos  = 8'h00;
      nslot = slot + 4'h1;
    end
    else
    begin
      npos  = pos + 8'h01;
      nslot = slot;
    end
    load = (npos == 8'h00) && (nslot < nslots);
    wsrc = load ? tx_data : word;
  end

  // Bit and word clock value for the next bit
  always_comb
  begin
    bidx     = 8'h1f - (npos - lead);
    next_sdo = 1'b0;
    if (nslot < nslots && npos >= lead && npos < lead + wlb)
      next_sdo = wsrc[bidx[4:0]];
    case (cfg_mode)
      SAIR_OL1: next_lrck = (nb < SAIR_OL1_HIGH_BITS);
      SAIR_OL2: next_lrck = (nb < SAIR_OL2_HIGH_BITS);
      SAIR_TDM: next_lrck = (nb == fl - 9'h001);
      default:  next_lrck = (nslot == 4'h0);
    endcase
  end

  // Bit clock divider; new bits launch on the fall, half a period before use
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dcnt <= 8'h00;
      sclk <= 1'b0;
    end
    else if (dcnt == div_last)
    begin
      dcnt <= 8'h00;
      sclk <= ~sclk;
    end
    else
      dcnt <= dcnt + 8'h01;
  end

  // Frame position and serial outputs
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      b    <= 9'h1ff;
      pos  <= 8'h00;
      slot <= 4'h0;
      lrck <= 1'b0;
      sdo  <= 1'b0;
    end
    else if (fall)
    begin
      b    <= nb;
      pos  <= npos;
      slot <= nslot;
      lrck <= next_lrck;
      sdo  <= next_sdo;
    end
  end

  // Word loading; tx_slot names the slot that the next load takes
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      word    <= SAIR_SAMPLE_RST;
      tx_slot <= SAIR_SLOT_RST;
      tx_load <= 1'b0;
    end
    else
    begin
      tx_load <= fall && load;
      if (fall && load)
      begin
        word    <= tx_data;
        tx_slot <= (nslot + 4'h1 >= nslots) ? 4'h0 : nslot + 4'h1;
      end
    end
  end

  assign link.serial_bit_clock = sclk;
  assign link.frame_word_clock = lrck;
  assign link.serial_data_in   = sdo;

endmodule

// [dv/sair_link_monitor.sv]
// Concurrent checks on the serial audio link wires and the receiver strobe
`timescale 1ns/1ns
module sair_link_monitor
  import sair_pkg::*;
#(
  parameter int RJ_HALF = SAIR_RJ_HALF_BITS
)
(
  // Core clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Format in use
  input wire sair_mode_t cfg_mode,
  // Link wires
  input wire logic       serial_bit_clock,
  input wire logic       frame_word_clock,
  input wire logic       serial_data_in,
  // Receiver strobe
  input wire logic       rx_valid
);
  logic [8:0] hi_cnt;
  logic [8:0] fr_cnt;
  logic [8:0] hf_cnt;
  logic       seen;
  logic [9:0] fr_cyc;
  logic       fast;

  // Frame length limits in core cycles for the 32 to 96 kHz framed range
  localparam int FR_MIN_CYC = 1000000 / (96 * SAIR_CORE_PERIOD_NS);
  localparam int FR_MAX_CYC = 1000000 / (32 * SAIR_CORE_PERIOD_NS);

  // 256 Fs formats toggle the bit clock on every core cycle
  assign fast = (cfg_mode == SAIR_OL2) || (cfg_mode == SAIR_TDM);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Bit clock rises counted in the core domain; seen skips the partial first frame
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      hi_cnt <= 9'h0;
      fr_cnt <= 9'h0;
      hf_cnt <= 9'h0;
      seen   <= 1'b0;
      fr_cyc <= 10'h000;
    end
    else
    begin
      hi_cnt <= $fell(frame_word_clock) ? 9'h0 : hi_cnt + 9'((frame_word_clock && $rose(serial_bit_clock)));
      fr_cnt <= $rose(frame_word_clock) ? 9'h0 : fr_cnt + 9'($rose(serial_bit_clock));
      hf_cnt <= $changed(frame_word_clock) ? 9'h0 : hf_cnt + 9'($rose(serial_bit_clock));
      seen   <= seen | $changed(frame_word_clock);
      fr_cyc <= $rose(frame_word_clock) ? 10'h001 : fr_cyc + 10'h001;
    end
  end

  // Divided bit clock phases, two core cycles each
  sequence bit_high_s;
    serial_bit_clock [*2] ##1 !serial_bit_clock;
  endsequence
  sequence bit_low_s;
    !serial_bit_clock [*2] ##1 serial_bit_clock;
  endsequence

  sclk_high_a: assert property ($rose(serial_bit_clock) && !fast |-> bit_high_s)
    else $error("bit clock high phase wrong");
  sclk_low_a: assert property ($fell(serial_bit_clock) && !fast |-> bit_low_s)
    else $error("bit clock low phase wrong");
  sclk_fast_a: assert property ($changed(serial_bit_clock) && fast
    |=> $changed(serial_bit_clock))
    else $error("fast bit clock phase wrong");
  frame_rate_a: assert property ($rose(frame_word_clock) && seen && cfg_mode != SAIR_RJ
    |-> fr_cyc >= FR_MIN_CYC && fr_cyc <= FR_MAX_CYC)
    else $error("frame rate outside framed range");
  data_edge_a: assert property ($changed(serial_data_in) |-> $fell(serial_bit_clock))
    else $error("data moved away from bit clock fall");
  lrck_edge_a: assert property ($changed(frame_word_clock) |-> $fell(serial_bit_clock))
    else $error("word clock moved away from bit clock fall");
  ol1_high_a: assert property ($fell(frame_word_clock) && cfg_mode == SAIR_OL1
    |-> hi_cnt == SAIR_OL1_HIGH_BITS)
    else $error("one-line 1 word clock high length wrong");
  ol2_high_a: assert property ($fell(frame_word_clock) && cfg_mode == SAIR_OL2
    |-> hi_cnt == SAIR_OL2_HIGH_BITS)
    else $error("one-line 2 word clock high length wrong");
  tdm_pulse_a: assert property ($fell(frame_word_clock) && cfg_mode == SAIR_TDM
    |-> hi_cnt == 9'h001)
    else $error("frame pulse length wrong");
  frame_len_a: assert property ($rose(frame_word_clock) && seen && cfg_mode != SAIR_RJ
    |-> fr_cnt == (cfg_mode == SAIR_OL1 ? SAIR_OL1_FRAME_BITS : SAIR_OL2_FRAME_BITS))
    else $error("frame length wrong");
  rj_half_a: assert property ($changed(frame_word_clock) && seen && cfg_mode == SAIR_RJ
    |-> hf_cnt == 9'(RJ_HALF))
    else $error("right-justified half length wrong");
  valid_pulse_a: assert property (rx_valid |=> !rx_valid [*8])
    else $error("strobe too long or too close");
endmodule

// [dv/serial_audio_input_receiver_tb.sv]
// Bench joining source and receiver ends and checking every received word but the first of each right-justified run
`timescale 1ns/1ns
module serial_audio_input_receiver_tb;
  import sair_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b0;
  sair_mode_t  cfg_mode = SAIR_RJ;
  sair_wl_t    cfg_wl = SAIR_WL16;
  logic [31:0] words [16] = '{default: 32'h0};
  logic [31:0] rx_sample;
  logic [3:0]  rx_slot;
  logic        rx_valid;
  logic [3:0]  tx_slot;
  logic        tx_load;
  int          num_errors = 0;
  int          checked = 0;
  sair_if      link ();

  // Core clock, 25 MHz
  always #20 core_clk = ~core_clk;

  // Source takes each slot's word from the per-test table
  sair_src u_sair_src (
    .core_clk (core_clk),
    .rst      (rst),
    .cfg_mode (cfg_mode),
    .cfg_wl   (cfg_wl),
    .link     (link.src),
    .tx_data  (words[tx_slot]),
    .tx_slot  (tx_slot),
    .tx_load  (tx_load)
  );

  sair_rx u_sair_rx (
    .core_clk  (core_clk),
    .rst       (rst),
    .cfg_mode  (cfg_mode),
    .cfg_wl    (cfg_wl),
    .link      (link.rx),
    .rx_sample (rx_sample),
    .rx_slot   (rx_slot),
    .rx_valid  (rx_valid)
  );

  sair_link_monitor u_sair_link_monitor (
    .core_clk         (core_clk),
    .rst              (rst),
    .cfg_mode         (cfg_mode),
    .serial_bit_clock (link.serial_bit_clock),
    .frame_word_clock (link.frame_word_clock),
    .serial_data_in   (link.serial_data_in),
    .rx_valid         (rx_valid)
  );

  // Word as it should arrive: top bits kept, length clamped by slot or format
  function automatic logic [31:0] expect_word(logic [31:0] w, sair_mode_t m, sair_wl_t l);
    int n;
    n = (l == 3'h1) ? 18 : (l == 3'h2) ? 20 : (l == 3'h3) ? 24 : (l == 3'h4) ? 32 : 16;
    if (m == SAIR_RJ)
      n = (l == 3'h3) ? 24 : 16;
    if (m == SAIR_OL1 && n > 20)
      n = 20;
    if (m == SAIR_OL2 && n > 24)
      n = 24;
    return w & ~(32'hffffffff >> n);
  endfunction

  task automatic flag(string msg);
    num_errors++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask

  task automatic cmp_word(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp)
      flag($sformatf("word %h, expected %h", got, exp));
  endtask

  task automatic cmp_slot(logic [3:0] got, logic [3:0] exp);
    checked++;
    if (got !== exp)
      flag($sformatf("slot %h, expected %h", got, exp));
  endtask

  task automatic conclude();
    $display("checked %0d, num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // One format and length: reset with new settings, then follow three frames
  task automatic run(sair_mode_t m, sair_wl_t l, int ns);
    int p;
    int nl;
    logic [3:0] last;
    @(posedge core_clk);
    #1;
    rst = 1'b1;
    cfg_mode = m;
    cfg_wl = l;
    foreach (words[i])
      words[i] = $urandom;
    words[0] = 32'hffffffff; // All ones shows any bit kept past the length
    words[1] = 32'h80000001; // Lone end bits catch order and alignment slips
    repeat (30) @(posedge core_clk);
    #1;
    rst = 1'b0;
    p = 0;
    nl = 0;
    last = 4'h0;
    for (int c = 0; c < 6000 && p < 3 * ns; c++)
    begin
      @(posedge core_clk);
      #2;
      // Each load names the slot that follows it, wrapping at the frame end
      if (tx_load === 1'b1)
      begin
        nl++;
        cmp_slot(tx_slot, 4'(nl % ns));
      end
      if (rx_valid === 1'b1)
      begin
        if (p > 0)
          cmp_slot(rx_slot, 4'((int'(last) + 1) % ns));
        // First right-justified half may follow a partial one, so it is skipped
        if (p > 0 || m != SAIR_RJ)
          cmp_word(rx_sample, expect_word(words[rx_slot], m, l));
        last = rx_slot;
        p++;
      end
    end
    if (p < 3 * ns)
      flag("too few words received");
    $display("test mode %h wl %0d: %0d words", m, l, p);
  endtask

  initial
  begin
    sair_mode_t modes [4];
    int nsl [4];
    modes = '{SAIR_RJ, SAIR_OL1, SAIR_OL2, SAIR_TDM};
    nsl = '{2, 6, 10, 8};
    void'($urandom(75));
    // A real rising edge of reset, so the link side clears without a bit clock
    #1;
    rst = 1'b1;
    repeat (10) @(posedge core_clk);
    for (int i = 0; i < 4; i++)
      for (int w = 0; w < 5; w++)
        run(modes[i], sair_wl_t'(w), nsl[i]);
    conclude();
  end

  // Cut a hang short well past the longest run of all tests
  initial
  begin
    #3000000;
    flag("watchdog expired");
    conclude();
  end
endmodule
